// ### common/meter_cfg_pkg.sv
// Purpose: Constants and carriers for the meter setup and calibration bank
// Assumes: 50 MHz ref_clk, word-indexed register port, 32-bit data
// Notes: Offsets and named field positions are fixed here; accumulation mode and voltage fields are sliced by bit number
package meter_cfg_pkg;
	localparam int ADDR_W = 6;
	// Register word offsets
	localparam logic [5:0] OFS_GAIN = 6'h00;
	localparam logic [5:0] OFS_CFG0 = 6'h01;
	localparam logic [5:0] OFS_CFG2 = 6'h02;
	localparam logic [5:0] OFS_ACCUM_MODE = 6'h03;
	localparam logic [5:0] OFS_INTCOEF = 6'h04;
	localparam logic [5:0] OFS_NOM_LEVEL = 6'h05;
	localparam logic [5:0] OFS_EPCFG = 6'h06;
	localparam logic [5:0] OFS_EGYTIME = 6'h07;
	localparam logic [5:0] OFS_ACT_NL = 6'h08;
	localparam logic [5:0] OFS_REACT_NL = 6'h09;
	localparam logic [5:0] OFS_APP_NL = 6'h0A;
	localparam logic [5:0] OFS_IEN0 = 6'h0B;
	localparam logic [5:0] OFS_IEN1 = 6'h0C;
	localparam logic [5:0] OFS_STAT0 = 6'h0D;
	localparam logic [5:0] OFS_STAT1 = 6'h0E;
	localparam logic [5:0] OFS_RUN = 6'h0F;
	localparam logic [5:0] OFS_WRLOCK = 6'h10;
	localparam logic [5:0] OFS_ACT_EGY = 6'h11;
	localparam logic [5:0] OFS_REACT_EGY = 6'h12;
	localparam logic [5:0] OFS_FS_RMS = 6'h13;
	localparam logic [5:0] OFS_FS_PWR = 6'h14;
	// Field positions
	localparam int C0_HPF_DIS = 0;
	localparam int C0_INT_EN = 1;
	localparam int C0_INT_INIT = 2;
	localparam int C0_ZX_SRC = 3;
	localparam int AM_LINE_FREQ = 8;
	localparam int EP_EN = 0;
	localparam int EP_RDRST = 1;
	localparam int EP_LDACC = 2;
	localparam int EP_TMRMODE = 3;
	localparam int EP_NLTMR_LO = 13;
	localparam int ST0_ENERGY_READY = 0;
	localparam int ST0_NOLOAD = 1;
	localparam int ST1_RESET_DONE = 0;
	// Reset values, keys and fixed constants
	localparam logic [2:0] CORNER_RST = 3'h6;
	localparam logic [31:0] IEN1_RST = 32'h0000_0001;
	localparam logic [15:0] LOCK_KEY = 16'h3C64;
	localparam logic [31:0] FS_RMS_CODES = 32'h0324_2B8C;
	localparam logic [31:0] FS_PWR_CODES = 32'h013B_C432;
	localparam int GAIN_FRAC_BITS = 27;
	localparam logic [15:0] NOLOAD_BASE = 16'h0040;
	// Timing
	localparam int CLK_PERIOD_NS = 20;
	localparam int RESET_DONE_NS = 50000;
	localparam int RESET_DONE_CYC = (RESET_DONE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	typedef enum logic [1:0] {
		ACC_SIGNED = 2'h0,
		ACC_ABS = 2'h1,
		ACC_POS = 2'h2,
		ACC_NEG = 2'h3
	} accum_mode_e;
	typedef struct packed {
		logic [5:0] addr;
		logic [31:0] wdata;
		logic wr;
		logic rd;
	} reg_req_s;
	typedef struct packed {
		logic valid;
		logic signed [31:0] active;
		logic signed [31:0] reactive;
		logic signed [31:0] apparent;
	} power_sample_s;
endpackage

// ### verilog/meter_dsp_setup.sv
// Purpose: Setup, calibration and energy bank of a multiphase metering DSP
// Assumes: Inputs synchronous to ref_clk; read data one cycle after rd
// Notes: All state in one packed struct, registered in one process
`timescale 1ns/1ps
module meter_dsp_setup #(
	parameter int RESET_CYC = meter_cfg_pkg::RESET_DONE_CYC
) (
	input wire logic ref_clk, // 50 MHz clock
	input wire logic nrst, // Synchronous reset, active low
	input wire meter_cfg_pkg::reg_req_s bus_req, // Register request
	output logic [31:0] bus_rdata, // Read data, cycle after rd
	input wire logic power_select_hi_pin, // Power mode pin, high bit
	input wire logic power_select_lo_pin, // Power mode pin, low bit
	input wire meter_cfg_pkg::power_sample_s pwr_in, // Per-sample powers
	input wire logic half_cycle_tick, // Half line cycle pulse
	input wire logic signed [31:0] cur_a_in, // Phase A current sample
	input wire logic signed [31:0] zx_pre_in, // Sample before filters
	input wire logic signed [31:0] zx_post_in, // Sample after filters
	output logic signed [31:0] cur_a_out, // Gain-corrected current
	output logic signed [31:0] zx_sample, // Zero-cross source sample
	output logic normal_power_state, // Normal measurement mode
	output logic dsp_running, // Core processing enabled
	output logic hpf_enable, // Highpass active
	output logic [2:0] highpass_corner_field, // Corner code
	output logic integrator_enable_bit, // Integrator on
	output logic integrator_init_bit, // Integrator initialise
	output logic line_freq_select_bit, // 0 50 Hz, 1 60 Hz
	output logic [2:0] voltage_config_select, // Voltage wiring code
	output logic noload_active, // No-load detected
	output logic interrupt_pin_zero_n, // Interrupt pin 0, active low
	output logic interrupt_pin_one_n // Interrupt pin 1, active low
);
	typedef struct packed {
		logic [31:0] gain;
		logic [31:0] cfg0;
		logic [2:0] corner;
		logic [31:0] acc_mode;
		logic [31:0] intcoef;
		logic [31:0] nom_level;
		logic [15:0] epcfg;
		logic [15:0] egytime;
		logic [31:0] act_nl;
		logic [31:0] react_nl;
		logic [31:0] app_nl;
		logic [31:0] ien0;
		logic [31:0] ien1;
		logic [31:0] stat0;
		logic [31:0] stat1;
		logic run;
		logic locked;
		logic signed [31:0] act_int;
		logic signed [31:0] react_int;
		logic signed [31:0] act_user;
		logic signed [31:0] react_user;
		logic [15:0] period_cnt;
		logic [15:0] nl_cnt;
		logic noload;
		logic [11:0] rst_cnt;
		logic rst_done;
		logic [31:0] rdata;
		logic signed [31:0] cur_out;
		logic signed [31:0] zx;
		logic normal;
		logic pin0_n;
		logic pin1_n;
		logic running;
		logic hpf_on;
	} state_s;

	state_s state_reg, state_next;
	logic signed [31:0] act_total, react_total;
	logic egy_event, tick, accum_on, wr_ok, user_clear;
	logic signed [63:0] gain_prod;

	// Selected contribution of one sample for a mode
	function automatic logic signed [31:0] acc_term(input logic [1:0] mode,
			input logic signed [31:0] p);
		logic signed [31:0] r;
		r = p;
		case (mode)
			meter_cfg_pkg::ACC_ABS: r = p[31] ? -p : p;
			meter_cfg_pkg::ACC_POS: r = p[31] ? 32'sh0 : p;
			meter_cfg_pkg::ACC_NEG: r = p[31] ? p : 32'sh0;
			default: r = p;
		endcase
		return r;
	endfunction

	// Magnitude, so thresholds compare against either sign
	function automatic logic [31:0] mag(input logic signed [31:0] p);
		return p[31] ? 32'(-p) : 32'(p);
	endfunction

	// ==========================================================
	// Next-state logic
	always_comb begin
		state_next = state_reg;
		wr_ok = bus_req.wr && !state_reg.locked;
		accum_on = state_reg.run && state_reg.epcfg[meter_cfg_pkg::EP_EN] && state_reg.normal;
		tick = state_reg.epcfg[meter_cfg_pkg::EP_TMRMODE] ? half_cycle_tick : pwr_in.valid;
		// value plus one ticks per period
		egy_event = accum_on && tick && (state_reg.period_cnt == state_reg.egytime);
		act_total = state_reg.act_int;
		react_total = state_reg.react_int;
		if (accum_on && pwr_in.valid && !state_reg.noload) begin
			act_total = state_reg.act_int + acc_term(state_reg.acc_mode[1:0], pwr_in.active);
			react_total = state_reg.react_int + acc_term(state_reg.acc_mode[3:2], pwr_in.reactive);
		end
		user_clear = bus_req.rd && state_reg.epcfg[meter_cfg_pkg::EP_RDRST] &&
			(bus_req.addr == meter_cfg_pkg::OFS_ACT_EGY ||
			bus_req.addr == meter_cfg_pkg::OFS_REACT_EGY);
		gain_prod = 64'(cur_a_in) * 64'(signed'(state_reg.gain));

		// both pins low means normal mode
		state_next.normal = !power_select_hi_pin && !power_select_lo_pin;

		// Register writes; status is write-one-to-clear and ignores the lock
		if (bus_req.wr && bus_req.addr == meter_cfg_pkg::OFS_STAT0)
			state_next.stat0 = state_reg.stat0 & ~bus_req.wdata;
		if (bus_req.wr && bus_req.addr == meter_cfg_pkg::OFS_STAT1)
			state_next.stat1 = state_next.stat1 & ~bus_req.wdata;
		if (wr_ok) begin
			case (bus_req.addr)
				meter_cfg_pkg::OFS_GAIN: state_next.gain = bus_req.wdata;
				meter_cfg_pkg::OFS_CFG0: state_next.cfg0 = bus_req.wdata;
				meter_cfg_pkg::OFS_CFG2: state_next.corner = bus_req.wdata[2:0];
				meter_cfg_pkg::OFS_ACCUM_MODE: state_next.acc_mode = bus_req.wdata;
				meter_cfg_pkg::OFS_INTCOEF: state_next.intcoef = bus_req.wdata;
				meter_cfg_pkg::OFS_NOM_LEVEL: state_next.nom_level = bus_req.wdata;
				meter_cfg_pkg::OFS_EPCFG: state_next.epcfg = bus_req.wdata[15:0];
				meter_cfg_pkg::OFS_EGYTIME: state_next.egytime = bus_req.wdata[15:0];
				meter_cfg_pkg::OFS_ACT_NL: state_next.act_nl = bus_req.wdata;
				meter_cfg_pkg::OFS_REACT_NL: state_next.react_nl = bus_req.wdata;
				meter_cfg_pkg::OFS_APP_NL: state_next.app_nl = bus_req.wdata;
				meter_cfg_pkg::OFS_IEN0: state_next.ien0 = bus_req.wdata;
				meter_cfg_pkg::OFS_IEN1: state_next.ien1 = bus_req.wdata;
				meter_cfg_pkg::OFS_RUN: state_next.run = bus_req.wdata[0];
				meter_cfg_pkg::OFS_WRLOCK:
					state_next.locked = (bus_req.wdata[15:0] == meter_cfg_pkg::LOCK_KEY);
				default: state_next.gain = state_next.gain;
			endcase
		end

		// Power-up completion counter, after the clears so its set wins
		if (!state_reg.rst_done) begin
			if (state_reg.rst_cnt == 12'(RESET_CYC - 1)) begin
				state_next.rst_done = 1'b1;
				state_next.stat1[meter_cfg_pkg::ST1_RESET_DONE] = 1'b1;
			end else begin
				state_next.rst_cnt = state_reg.rst_cnt + 12'h001;
			end
		end

		if (pwr_in.valid && state_reg.run) begin
			if (mag(pwr_in.active) < state_reg.act_nl &&
					mag(pwr_in.reactive) < state_reg.react_nl &&
					mag(pwr_in.apparent) < state_reg.app_nl) begin
				if (state_reg.nl_cnt == (meter_cfg_pkg::NOLOAD_BASE <<
						state_reg.epcfg[meter_cfg_pkg::EP_NLTMR_LO +: 3])) begin
					if (!state_reg.noload)
						state_next.stat0[meter_cfg_pkg::ST0_NOLOAD] = 1'b1;
					state_next.noload = 1'b1;
				end else begin
					state_next.nl_cnt = state_reg.nl_cnt + 16'h0001;
				end
			end else begin
				state_next.nl_cnt = 16'h0000;
				state_next.noload = 1'b0;
			end
		end

		// Accumulation, period count and user energy
		state_next.act_int = act_total;
		state_next.react_int = react_total;
		if (user_clear) begin
			state_next.act_user = (bus_req.addr == meter_cfg_pkg::OFS_ACT_EGY) ?
				32'sh0 : state_reg.act_user;
			state_next.react_user = (bus_req.addr == meter_cfg_pkg::OFS_REACT_EGY) ?
				32'sh0 : state_reg.react_user;
		end
		if (accum_on && tick)
			state_next.period_cnt = egy_event ? 16'h0000 : state_reg.period_cnt + 16'h0001;
		if (egy_event) begin
			if (state_reg.epcfg[meter_cfg_pkg::EP_LDACC]) begin
				state_next.act_user = act_total;
				state_next.react_user = react_total;
			end else begin
				state_next.act_user = state_next.act_user + act_total;
				state_next.react_user = state_next.react_user + react_total;
			end
			state_next.act_int = 32'sh0;
			state_next.react_int = 32'sh0;
			// Event set wins over a same-cycle clear
			state_next.stat0[meter_cfg_pkg::ST0_ENERGY_READY] = 1'b1;
		end

		if (state_reg.run && state_reg.normal)
			state_next.cur_out = cur_a_in + 32'(gain_prod >>> meter_cfg_pkg::GAIN_FRAC_BITS);
		state_next.zx = state_reg.cfg0[meter_cfg_pkg::C0_ZX_SRC] ? zx_pre_in : zx_post_in;

		// Read data, unmapped reads as zero
		state_next.rdata = 32'h0000_0000;
		if (bus_req.rd) begin
			case (bus_req.addr)
				meter_cfg_pkg::OFS_GAIN: state_next.rdata = state_reg.gain;
				meter_cfg_pkg::OFS_CFG0: state_next.rdata = state_reg.cfg0;
				meter_cfg_pkg::OFS_CFG2: state_next.rdata = {29'h0, state_reg.corner};
				meter_cfg_pkg::OFS_ACCUM_MODE: state_next.rdata = state_reg.acc_mode;
				meter_cfg_pkg::OFS_INTCOEF: state_next.rdata = state_reg.intcoef;
				meter_cfg_pkg::OFS_NOM_LEVEL: state_next.rdata = state_reg.nom_level;
				meter_cfg_pkg::OFS_EPCFG: state_next.rdata = {16'h0, state_reg.epcfg};
				meter_cfg_pkg::OFS_EGYTIME: state_next.rdata = {16'h0, state_reg.egytime};
				meter_cfg_pkg::OFS_ACT_NL: state_next.rdata = state_reg.act_nl;
				meter_cfg_pkg::OFS_REACT_NL: state_next.rdata = state_reg.react_nl;
				meter_cfg_pkg::OFS_APP_NL: state_next.rdata = state_reg.app_nl;
				meter_cfg_pkg::OFS_IEN0: state_next.rdata = state_reg.ien0;
				meter_cfg_pkg::OFS_IEN1: state_next.rdata = state_reg.ien1;
				meter_cfg_pkg::OFS_STAT0: state_next.rdata = state_reg.stat0;
				meter_cfg_pkg::OFS_STAT1: state_next.rdata = state_reg.stat1;
				meter_cfg_pkg::OFS_RUN: state_next.rdata = {31'h0, state_reg.run};
				meter_cfg_pkg::OFS_WRLOCK: state_next.rdata = {31'h0, state_reg.locked};
				meter_cfg_pkg::OFS_ACT_EGY: state_next.rdata = state_reg.act_user;
				meter_cfg_pkg::OFS_REACT_EGY: state_next.rdata = state_reg.react_user;
				meter_cfg_pkg::OFS_FS_RMS: state_next.rdata = meter_cfg_pkg::FS_RMS_CODES;
				meter_cfg_pkg::OFS_FS_PWR: state_next.rdata = meter_cfg_pkg::FS_PWR_CODES;
				default: state_next.rdata = 32'h0000_0000;
			endcase
		end

		// each pin from its own mask and status
		state_next.pin0_n = ~|(state_next.stat0 & state_next.ien0);
		state_next.pin1_n = ~|(state_next.stat1 & state_next.ien1);
		// Registered copies, so no gate sits between flop and pin
		state_next.running = state_next.run && state_next.normal;
		state_next.hpf_on = !state_next.cfg0[meter_cfg_pkg::C0_HPF_DIS];
	end

	// ==========================================================
	// State register
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			state_reg <= '0;
			state_reg.corner <= meter_cfg_pkg::CORNER_RST;
			// Reset-done shows on pin 1 without software help
			state_reg.ien1 <= meter_cfg_pkg::IEN1_RST;
			state_reg.pin0_n <= 1'b1;
			state_reg.pin1_n <= 1'b1;
			state_reg.hpf_on <= 1'b1;
		end else begin
			state_reg <= state_next;
		end
	end

	// ==========================================================
	// Outputs, all taken from the state register
	assign bus_rdata = state_reg.rdata;
	assign cur_a_out = state_reg.cur_out;
	assign zx_sample = state_reg.zx;
	assign normal_power_state = state_reg.normal;
	assign dsp_running = state_reg.running;
	assign hpf_enable = state_reg.hpf_on;
	assign highpass_corner_field = state_reg.corner;
	assign integrator_enable_bit = state_reg.cfg0[meter_cfg_pkg::C0_INT_EN];
	assign integrator_init_bit = state_reg.cfg0[meter_cfg_pkg::C0_INT_INIT];
	assign line_freq_select_bit = state_reg.acc_mode[meter_cfg_pkg::AM_LINE_FREQ];
	assign voltage_config_select = state_reg.acc_mode[6:4];
	assign noload_active = state_reg.noload;
	assign interrupt_pin_zero_n = state_reg.pin0_n;
	assign interrupt_pin_one_n = state_reg.pin1_n;

	// ==========================================================
	// Assertions
	property p_rst_done_irq;
		@(posedge ref_clk) disable iff (!nrst)
		(state_reg.stat1[meter_cfg_pkg::ST1_RESET_DONE] && state_reg.ien1[0])
			|-> !interrupt_pin_one_n;
	endproperty
	a_rst_done_irq: assert property (p_rst_done_irq) else $error("reset done not on pin");

	property p_normal_mode;
		@(posedge ref_clk) disable iff (!nrst)
		(!power_select_hi_pin && !power_select_lo_pin) |=> normal_power_state;
	endproperty
	a_normal_mode: assert property (p_normal_mode) else $error("normal mode missed");

	property p_hpf_reset;
		@(posedge ref_clk) disable iff (!nrst)
		!$past(nrst) |-> (highpass_corner_field == 3'h6 && hpf_enable && !integrator_enable_bit);
	endproperty
	a_hpf_reset: assert property (p_hpf_reset) else $error("filter reset state wrong");

	property p_load_overwrite;
		@(posedge ref_clk) disable iff (!nrst)
		(egy_event && state_reg.epcfg[meter_cfg_pkg::EP_LDACC])
			|=> (state_reg.act_user == $past(act_total));
	endproperty
	a_load_overwrite: assert property (p_load_overwrite) else $error("overwrite wrong");

	property p_read_clear;
		@(posedge ref_clk) disable iff (!nrst)
		(user_clear && bus_req.addr == meter_cfg_pkg::OFS_ACT_EGY && !egy_event)
			|=> (state_reg.act_user == 32'sh0);
	endproperty
	a_read_clear: assert property (p_read_clear) else $error("clearing read failed");

	property p_interrupt_pin_zero;
		@(posedge ref_clk) disable iff (!nrst)
		(egy_event && state_reg.ien0[meter_cfg_pkg::ST0_ENERGY_READY]) |=> !interrupt_pin_zero_n;
	endproperty
	a_interrupt_pin_zero: assert property (p_interrupt_pin_zero) else $error("pin 0 not asserted");

	property p_no_run_hold;
		@(posedge ref_clk) disable iff (!nrst)
		(!state_reg.run && !egy_event) |=> $stable(state_reg.act_int);
	endproperty
	a_no_run_hold: assert property (p_no_run_hold) else $error("accumulated while stopped");

	property p_lock_hold;
		@(posedge ref_clk) disable iff (!nrst)
		(state_reg.locked && bus_req.wr && bus_req.addr == meter_cfg_pkg::OFS_CFG0)
			|=> $stable(state_reg.cfg0) ##1 state_reg.locked;
	endproperty
	a_lock_hold: assert property (p_lock_hold) else $error("locked write took effect");

	property p_noload_hold;
		@(posedge ref_clk) disable iff (!nrst)
		(state_reg.noload && !egy_event) |=> $stable(state_reg.act_int);
	endproperty
	a_noload_hold: assert property (p_noload_hold) else $error("noise accumulated");

	property p_period;
		@(posedge ref_clk) disable iff (!nrst)
		(accum_on && tick && state_reg.period_cnt == state_reg.egytime)
			|=> (state_reg.period_cnt == 16'h0000 &&
			state_reg.stat0[meter_cfg_pkg::ST0_ENERGY_READY]);
	endproperty
	a_period: assert property (p_period) else $error("period end missed");
endmodule

// ### verification/meter_host_model.sv
// Purpose: Host model that drives the register port and power pins
// Assumes: Requests change right after a rising edge of ref_clk
// Notes: Idle address and data are inverted so stale values never look valid
`timescale 1ns/1ps
module meter_host_model (
	input wire logic ref_clk, // Device clock
	output meter_cfg_pkg::reg_req_s bus_req, // Register request
	input wire logic [31:0] bus_rdata, // Read data
	output logic power_select_hi_pin, // Power pin, high bit
	output logic power_select_lo_pin // Power pin, low bit
);
	// ==========
	// Bus cycles
	// Idle state: no strobe, pins away from normal mode
	initial begin
		bus_req = '0;
		power_select_hi_pin = 1'b1;
		power_select_lo_pin = 1'b1;
	end
	// Single write strobe, then scramble the idle fields
	task automatic wr(input logic [5:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge ref_clk);
		bus_req <= '{addr: ~a, wdata: ~d, wr: 1'b0, rd: 1'b0};
	endtask
	// Data only stand in the cycle after the strobe
	task automatic rd(input logic [5:0] a, output logic [31:0] d);
		@(posedge ref_clk);
		bus_req <= '{addr: a, wdata: 32'h0000_0000, wr: 1'b0, rd: 1'b1};
		@(posedge ref_clk);
		bus_req <= '{addr: ~a, wdata: 32'hFFFF_FFFF, wr: 1'b0, rd: 1'b0};
		#1;
		d = bus_rdata;
	endtask
	task automatic pins(input logic h, input logic l);
		@(posedge ref_clk);
		power_select_hi_pin <= h;
		power_select_lo_pin <= l;
	endtask
endmodule

// ### verification/meter_dsp_setup_tb.sv
// Purpose: Self-checking bench for the meter setup and calibration bank
// Assumes: Reset-done delay shortened to 8 cycles
// Notes: Energy periods are fed in whole groups so the period counter stays aligned
`timescale 1ns/1ps
module meter_dsp_setup_tb;
	logic ref_clk, nrst, half_cycle_tick, hpf_enable, dsp_running, normal_power_state;
	logic power_select_hi_pin, power_select_lo_pin, integrator_enable_bit, integrator_init_bit;
	logic line_freq_select_bit, noload_active, interrupt_pin_zero_n, interrupt_pin_one_n;
	logic [2:0] highpass_corner_field, voltage_config_select;
	logic [31:0] bus_rdata, rv;
	logic signed [31:0] cur_a_in, zx_pre_in, zx_post_in, cur_a_out, zx_sample;
	meter_cfg_pkg::reg_req_s bus_req;
	meter_cfg_pkg::power_sample_s pwr_in;
	logic [31:0] mexp [4] = '{32'hFFFF_FFFE, 32'h0000_0008, 32'h0000_0003, 32'hFFFF_FFFB};
	int err_total = 0;
	int checks = 0;
	int cyc = 0;
	// ==========
	// Instances
	meter_dsp_setup #(.RESET_CYC(8)) dut_u (.ref_clk, .nrst, .bus_req, .bus_rdata,
		.power_select_hi_pin, .power_select_lo_pin, .pwr_in, .half_cycle_tick, .cur_a_in,
		.zx_pre_in, .zx_post_in, .cur_a_out, .zx_sample, .normal_power_state, .dsp_running,
		.hpf_enable, .highpass_corner_field, .integrator_enable_bit, .integrator_init_bit,
		.line_freq_select_bit, .voltage_config_select, .noload_active, .interrupt_pin_zero_n,
		.interrupt_pin_one_n);
	meter_host_model host_u (.ref_clk, .bus_req, .bus_rdata, .power_select_hi_pin,
		.power_select_lo_pin);
	// ==========
	// Clock and watchdog
	initial begin
		ref_clk = 1'b0;
		forever #10 ref_clk = ~ref_clk;
	end
	// Hang guard, well above the expected run length
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 5000) begin
			err_total++;
			finish_test();
		end
	end
	// ==========
	// Helpers
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			err_total++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic chk1(input logic got, input logic exp);
		chk({31'h0, got}, {31'h0, exp});
	endtask
	task automatic rchk(input logic [5:0] a, input logic [31:0] e);
		host_u.rd(a, rv);
		chk(rv, e);
	endtask
	// Let the edge updates land before looking
	task automatic settle(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask
	// Samples with gaps; all three powers equal
	task automatic smp(input logic [31:0] a, input int n);
		repeat (n) begin
			@(posedge ref_clk);
			pwr_in <= '{valid: 1'b1, active: a, reactive: a, apparent: a};
			@(posedge ref_clk);
			pwr_in.valid <= 1'b0;
		end
		repeat (2) @(posedge ref_clk);
	endtask
	task automatic finish_test();
		$display("checks=%0d err_total=%0d", checks, err_total);
		if (err_total == 0 && checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	// ==========
	// Main sequence
	initial begin
		nrst = 1'b0;
		half_cycle_tick = 1'b0;
		pwr_in = '0;
		cur_a_in = 32'h0000_03E8;
		zx_pre_in = 32'h0000_0111;
		zx_post_in = 32'h0000_0222;
		settle(5);
		chk({28'h0, interrupt_pin_zero_n, interrupt_pin_one_n, hpf_enable, integrator_enable_bit},
			32'h0000_000E);
		chk({29'h0, highpass_corner_field}, 32'h0000_0006);
		@(posedge ref_clk);
		nrst <= 1'b1;
		settle(4);
		chk1(interrupt_pin_one_n, 1'b1);
		for (int i = 0; i < 20 && interrupt_pin_one_n !== 1'b0; i++) settle(1);
		chk1(interrupt_pin_one_n, 1'b0);
		rchk(meter_cfg_pkg::OFS_STAT1, 32'h0000_0001);
		host_u.wr(meter_cfg_pkg::OFS_STAT1, 32'h0000_0001);
		settle(2);
		chk1(interrupt_pin_one_n, 1'b1);
		chk1(normal_power_state, 1'b0);
		host_u.pins(1'b0, 1'b0);
		settle(3);
		chk1(normal_power_state, 1'b1);
		rchk(meter_cfg_pkg::OFS_CFG2, 32'h0000_0006);
		rchk(meter_cfg_pkg::OFS_ACCUM_MODE, 32'h0000_0000);
		host_u.wr(meter_cfg_pkg::OFS_CFG0, 32'h0000_000F);
		host_u.wr(meter_cfg_pkg::OFS_INTCOEF, 32'hFFFF_E000);
		host_u.wr(meter_cfg_pkg::OFS_NOM_LEVEL, 32'h0008_BA8A);
		host_u.wr(meter_cfg_pkg::OFS_ACCUM_MODE, 32'h0000_0120);
		host_u.wr(meter_cfg_pkg::OFS_CFG2, 32'h0000_0005);
		settle(2);
		chk({28'h0, hpf_enable, integrator_enable_bit, integrator_init_bit, line_freq_select_bit},
			32'h0000_0007);
		chk(zx_sample, 32'h0000_0111);
		chk({29'h0, highpass_corner_field}, 32'h0000_0005);
		chk({29'h0, voltage_config_select}, 32'h0000_0002);
		host_u.wr(meter_cfg_pkg::OFS_CFG0, 32'h0000_0000);
		host_u.wr(meter_cfg_pkg::OFS_ACCUM_MODE, 32'h0000_0000);
		settle(2);
		chk({28'h0, hpf_enable, integrator_enable_bit, integrator_init_bit, line_freq_select_bit},
			32'h0000_0008);
		chk(zx_sample, 32'h0000_0222);
		chk({29'h0, voltage_config_select}, 32'h0000_0000);
		rchk(meter_cfg_pkg::OFS_INTCOEF, 32'hFFFF_E000);
		rchk(meter_cfg_pkg::OFS_NOM_LEVEL, 32'h0008_BA8A);
		rchk(6'h3F, 32'h0000_0000);
		rchk(meter_cfg_pkg::OFS_FS_RMS, 32'h0324_2B8C);
		rchk(meter_cfg_pkg::OFS_FS_PWR, 32'h013B_C432);
		chk(cur_a_out, 32'h0000_0000);
		host_u.wr(meter_cfg_pkg::OFS_GAIN, 32'h0400_0000);
		host_u.wr(meter_cfg_pkg::OFS_RUN, 32'h0000_0001);
		settle(3);
		chk1(dsp_running, 1'b1);
		chk(cur_a_out, 32'h0000_05DC);
		// pulse outputs unused, threshold setup skipped
		host_u.wr(meter_cfg_pkg::OFS_IEN0, 32'h0000_0001);
		host_u.wr(meter_cfg_pkg::OFS_EGYTIME, 32'h0000_0003);
		host_u.wr(meter_cfg_pkg::OFS_EPCFG, 32'h0000_0005);
		smp(32'h0000_0005, 3);
		rchk(meter_cfg_pkg::OFS_STAT0, 32'h0000_0000);
		chk1(interrupt_pin_zero_n, 1'b1);
		smp(32'h0000_0005, 1);
		rchk(meter_cfg_pkg::OFS_STAT0, 32'h0000_0001);
		chk1(interrupt_pin_zero_n, 1'b0);
		rchk(meter_cfg_pkg::OFS_ACT_EGY, 32'h0000_0014);
		host_u.wr(meter_cfg_pkg::OFS_STAT0, 32'h0000_0001);
		host_u.wr(meter_cfg_pkg::OFS_EPCFG, 32'h0000_0001);
		smp(32'h0000_0005, 4);
		rchk(meter_cfg_pkg::OFS_ACT_EGY, 32'h0000_0028);
		rchk(meter_cfg_pkg::OFS_REACT_EGY, 32'h0000_0028);
		host_u.wr(meter_cfg_pkg::OFS_EGYTIME, 32'h0000_0001);
		host_u.wr(meter_cfg_pkg::OFS_EPCFG, 32'h0000_0005);
		for (int m = 0; m < 4; m++) begin
			host_u.wr(meter_cfg_pkg::OFS_ACCUM_MODE, 32'(m));
			smp(32'hFFFF_FFFB, 1);
			smp(32'h0000_0003, 1);
			rchk(meter_cfg_pkg::OFS_ACT_EGY, mexp[m]);
		end
		host_u.wr(meter_cfg_pkg::OFS_EPCFG, 32'h0000_0007);
		rchk(meter_cfg_pkg::OFS_ACT_EGY, 32'hFFFF_FFFB);
		rchk(meter_cfg_pkg::OFS_ACT_EGY, 32'h0000_0000);
		host_u.wr(meter_cfg_pkg::OFS_ACCUM_MODE, 32'h0000_0000);
		host_u.wr(meter_cfg_pkg::OFS_EPCFG, 32'h0000_000D);
		smp(32'h0000_0007, 1);
		repeat (2) begin
			@(posedge ref_clk);
			half_cycle_tick <= 1'b1;
			@(posedge ref_clk);
			half_cycle_tick <= 1'b0;
		end
		rchk(meter_cfg_pkg::OFS_ACT_EGY, 32'h0000_0007);
		host_u.wr(meter_cfg_pkg::OFS_EPCFG, 32'h0000_0005);
		host_u.wr(meter_cfg_pkg::OFS_ACT_NL, 32'h0000_0064);
		host_u.wr(meter_cfg_pkg::OFS_REACT_NL, 32'h0000_0064);
		host_u.wr(meter_cfg_pkg::OFS_APP_NL, 32'h0000_0064);
		smp(32'h0000_0001, 66);
		chk1(noload_active, 1'b1);
		rchk(meter_cfg_pkg::OFS_STAT0, 32'h0000_0003);
		smp(32'h0000_0001, 2);
		rchk(meter_cfg_pkg::OFS_ACT_EGY, 32'h0000_0000);
		host_u.wr(meter_cfg_pkg::OFS_WRLOCK, 32'h0000_3C64);
		host_u.wr(meter_cfg_pkg::OFS_CFG2, 32'h0000_0002);
		settle(2);
		chk({29'h0, highpass_corner_field}, 32'h0000_0005);
		rchk(meter_cfg_pkg::OFS_CFG2, 32'h0000_0005);
		finish_test();
	end
endmodule
